// ===== pkg/lpmkaf_pkg.sv
// Package with key and action layouts of the prefix match store.
package lpmkaf_pkg;

	// ----------------------------------------------------------------
	// Key sizes and word counts
	// ----------------------------------------------------------------
	localparam int unsigned SGL4_KEY_W = 33;
	localparam int unsigned DBL4_KEY_W = 64;
	localparam int unsigned SGL6_KEY_W = 129;
	localparam int unsigned DBL6_KEY_W = 256;
	localparam int unsigned SGL4_WORDS = 1;
	localparam int unsigned DBL4_WORDS = 2;
	localparam int unsigned SGL6_WORDS = 4;
	localparam int unsigned DBL6_WORDS = 8;
	localparam int unsigned WORD_W = 32;
	localparam int unsigned ENTRY_W = 256;

	// ----------------------------------------------------------------
	// Key field positions
	// ----------------------------------------------------------------
	localparam int unsigned DIR_POS = 0;
	localparam int unsigned XIP_POS = 1;
	localparam int unsigned DBL_SRC_POS = 0;
	localparam int unsigned DBL4_DST_POS = 32;
	localparam int unsigned DBL6_DST_POS = 128;

	// ----------------------------------------------------------------
	// Action layout
	// ----------------------------------------------------------------
	localparam int unsigned NHPTR_ACT_W = 18;
	localparam int unsigned MCPTR_ACT_W = 10;
	localparam int unsigned INLINE_ACT_W = 62;
	localparam int unsigned ACTION_W = 62;
	localparam int unsigned ATYPE_POS = 0;
	localparam int unsigned NH_IDX_POS = 2;
	localparam int unsigned REMAP_POS = 10;
	localparam int unsigned ECMP_POS = 11;
	localparam int unsigned ROUTE_GROUP_IDENTIFIER_POS = 15;
	localparam int unsigned MC_IDX_POS = 2;
	localparam int unsigned MAC_HI_POS = 2;
	localparam int unsigned MAC_LO_POS = 18;
	localparam int unsigned LEG_POS = 50;
	localparam int unsigned CPUQ_POS = 55;
	localparam int unsigned RPF_POS = 58;
	localparam int unsigned LEGM_POS = 59;
	localparam int unsigned MACM_POS = 60;
	localparam int unsigned VALID_POS = 61;

	typedef enum logic [1:0] {
		LPMKAF_ACT_NH_PTR = 2'h0,
		LPMKAF_ACT_MC_PTR = 2'h1,
		LPMKAF_ACT_INLINE = 2'h2,
		LPMKAF_ACT_RSVD = 2'h3
	} lpmkaf_act_t;

	typedef enum logic [1:0] {
		LPMKAF_KEY_SGL4 = 2'h0,
		LPMKAF_KEY_DBL4 = 2'h1,
		LPMKAF_KEY_SGL6 = 2'h2,
		LPMKAF_KEY_DBL6 = 2'h3
	} lpmkaf_key_t;

	// Lookup request from the routing and guard logic.
	typedef struct packed {
		lpmkaf_key_t key_type;
		logic lookup_direction_flag;
		logic [127:0] src_addr;
		logic [127:0] dst_addr;
	} lpmkaf_req_t;

	// Decoded action returned with each lookup.
	typedef struct packed {
		logic hit;
		logic act_ok;
		lpmkaf_act_t act_type;
		logic [7:0] nh_index;
		logic remap_ena;
		logic [3:0] equal_cost_path_count;
		logic [2:0] route_group_identifier;
		logic [7:0] mc_index;
		logic [15:0] mac_hi;
		logic [31:0] mac_lo;
		logic [4:0] leg_id;
		logic [2:0] zero_mac_cpu_queue;
		logic reverse_path_check_enable;
		logic leg_match_ena;
		logic mac_match_ena;
		logic entry_valid;
	} lpmkaf_rsp_t;

	// Response-valid state of the lookup pipe.
	typedef enum logic [0:0] {
		LPMKAF_ST_IDLE = 1'h0,
		LPMKAF_ST_DONE = 1'h1
	} lpmkaf_state_t;

endpackage

// ===== rtl/lpmkaf_store.sv
// Prefix match store with key packing, priority lookup and action decode.
`timescale 1ns/1ns
// Functional notes
// - Four keys: single v4 33b/1w, double v4 64b/2w, single v6 129b/4w, double v6 256b/8w.
// - Key fields packed in order, first field at entry bit 0.
// - Single keys start with direction flag: 0 source only, 1 destination only.
// - Single v4 key is flag plus 32-bit address for routing and guard.
// - Double v4 key is source then destination, 32 bits each, no flag.
// - Single v6 key is flag plus 128-bit address for routing and guard.
// - Double v6 key is source then destination, 128 bits each, no flag.
// - Action starts with 2-bit type: 0 pointer, 1 multicast, 2 inline, 3 reserved.
// - Action fields packed in order from bit 0, each directly above previous.
// - Next-hop pointer action is 18 bits, single keys only, 8-bit index.
// - Remap enable makes the pointer index the remap table instead.
// - Next-hop pointer carries a 4-bit equal-cost path count.
// - Next-hop pointer carries a 3-bit route group for reverse-path check.
// - Multicast pointer action is 10 bits, double keys only, 8-bit index.
// - Inline next-hop action is 62 bits, single keys only.
// - Inline holds MAC hi/lo, leg, CPU queue, rpf, leg, MAC match, valid.
// - Guard checks look source and destination up separately.
module lpmkaf_store #(
	parameter int unsigned ENTRIES = 16
) (
	input wire logic core_clk_i,
	input wire logic rst_b_i,
	input wire logic wr_en_i,
	input wire logic [$clog2(ENTRIES)-1:0] wr_index_i,
	input wire logic wr_valid_i,
	input wire lpmkaf_pkg::lpmkaf_key_t wr_key_type_i,
	input wire logic [lpmkaf_pkg::ENTRY_W-1:0] wr_key_i,
	input wire logic [lpmkaf_pkg::ENTRY_W-1:0] wr_mask_i,
	input wire logic [lpmkaf_pkg::ACTION_W-1:0] wr_action_i,
	input wire logic req_valid_i,
	input wire lpmkaf_pkg::lpmkaf_req_t req_i,
	output logic req_ready_o,
	output logic rsp_valid_o,
	output lpmkaf_pkg::lpmkaf_rsp_t rsp_o,
	output logic [lpmkaf_pkg::ENTRY_W-1:0] rsp_key_o
);

	// ----------------------------------------------------------------
	// Reset release
	// ----------------------------------------------------------------
	logic rst_meta_b;
	logic rst_sync_b;

	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rst_meta_b <= 1'b0;
			rst_sync_b <= 1'b0;
		end else begin
			rst_meta_b <= 1'b1;
			rst_sync_b <= rst_meta_b;
		end
	end

	// ----------------------------------------------------------------
	// Entry storage
	// ----------------------------------------------------------------
	logic [lpmkaf_pkg::ENTRY_W-1:0] key_mem [ENTRIES];
	logic [lpmkaf_pkg::ENTRY_W-1:0] mask_mem [ENTRIES];
	logic [lpmkaf_pkg::ACTION_W-1:0] act_mem [ENTRIES];
	lpmkaf_pkg::lpmkaf_key_t type_mem [ENTRIES];
	logic [ENTRIES-1:0] valid_mem;

	// Only valid bits are reset; content is don't-care until written.
	always_ff @(posedge core_clk_i or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			valid_mem <= '0;
		end else if (wr_en_i) begin
			valid_mem[wr_index_i] <= wr_valid_i;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (wr_en_i) begin
			key_mem[wr_index_i] <= wr_key_i;
			mask_mem[wr_index_i] <= wr_mask_i;
			act_mem[wr_index_i] <= wr_action_i;
			type_mem[wr_index_i] <= wr_key_type_i;
		end
	end

	// ----------------------------------------------------------------
	// Key packing
	// ----------------------------------------------------------------
	logic [lpmkaf_pkg::ENTRY_W-1:0] packed_key;
	logic [lpmkaf_pkg::ENTRY_W-1:0] key_width_mask;

	always_comb begin
		packed_key = '0;
		key_width_mask = '0;
		case (req_i.key_type)
			lpmkaf_pkg::LPMKAF_KEY_SGL4: begin
				packed_key[lpmkaf_pkg::DIR_POS] = req_i.lookup_direction_flag;
				packed_key[lpmkaf_pkg::XIP_POS +: 32] = req_i.lookup_direction_flag ?
					req_i.dst_addr[31:0] : req_i.src_addr[31:0];
				key_width_mask[lpmkaf_pkg::SGL4_KEY_W-1:0] = '1;
			end
			lpmkaf_pkg::LPMKAF_KEY_DBL4: begin
				packed_key[lpmkaf_pkg::DBL_SRC_POS +: 32] = req_i.src_addr[31:0];
				packed_key[lpmkaf_pkg::DBL4_DST_POS +: 32] = req_i.dst_addr[31:0];
				key_width_mask[lpmkaf_pkg::DBL4_KEY_W-1:0] = '1;
			end
			lpmkaf_pkg::LPMKAF_KEY_SGL6: begin
				packed_key[lpmkaf_pkg::DIR_POS] = req_i.lookup_direction_flag;
				packed_key[lpmkaf_pkg::XIP_POS +: 128] = req_i.lookup_direction_flag ?
					req_i.dst_addr : req_i.src_addr;
				key_width_mask[lpmkaf_pkg::SGL6_KEY_W-1:0] = '1;
			end
			lpmkaf_pkg::LPMKAF_KEY_DBL6: begin
				packed_key[lpmkaf_pkg::DBL_SRC_POS +: 128] = req_i.src_addr;
				packed_key[lpmkaf_pkg::DBL6_DST_POS +: 128] = req_i.dst_addr;
				key_width_mask = '1;
			end
			default: begin
				packed_key = '0;
				key_width_mask = '0;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// Match and priority
	// ----------------------------------------------------------------
	logic [ENTRIES-1:0] match_vec;
	logic any_hit;
	logic [$clog2(ENTRIES)-1:0] hit_index;

	// The direction flag is part of the key, so a source-only entry never
	// answers a destination lookup and guard lookups stay separate.
	always_comb begin
		for (int i = 0; i < ENTRIES; i++) begin
			match_vec[i] = valid_mem[i] && (type_mem[i] == req_i.key_type) &&
				(((key_mem[i] ^ packed_key) & mask_mem[i] & key_width_mask) == '0);
		end
	end

	// Lowest index wins; software places longer prefixes at lower indices.
	always_comb begin
		any_hit = 1'b0;
		hit_index = '0;
		for (int i = ENTRIES - 1; i >= 0; i--) begin
			if (match_vec[i]) begin
				any_hit = 1'b1;
				hit_index = i[$clog2(ENTRIES)-1:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// Action decode
	// ----------------------------------------------------------------
	logic [lpmkaf_pkg::ACTION_W-1:0] act;
	lpmkaf_pkg::lpmkaf_act_t act_type;
	logic single_key;
	lpmkaf_pkg::lpmkaf_rsp_t next_rsp;

	assign act = act_mem[hit_index];
	assign act_type = lpmkaf_pkg::lpmkaf_act_t'(act[lpmkaf_pkg::ATYPE_POS +: 2]);
	assign single_key = (req_i.key_type == lpmkaf_pkg::LPMKAF_KEY_SGL4) ||
		(req_i.key_type == lpmkaf_pkg::LPMKAF_KEY_SGL6);

	always_comb begin
		next_rsp = '0;
		next_rsp.hit = any_hit;
		// A miss reads slot 0, which did not match, so its type is only reported on a hit.
		if (any_hit) begin
			next_rsp.act_type = act_type;
			case (act_type)
				lpmkaf_pkg::LPMKAF_ACT_NH_PTR: begin
					next_rsp.act_ok = single_key;
					next_rsp.nh_index = act[lpmkaf_pkg::NH_IDX_POS +: 8];
					next_rsp.remap_ena = act[lpmkaf_pkg::REMAP_POS];
					next_rsp.equal_cost_path_count = act[lpmkaf_pkg::ECMP_POS +: 4];
					next_rsp.route_group_identifier = act[lpmkaf_pkg::ROUTE_GROUP_IDENTIFIER_POS +: 3];
				end
				lpmkaf_pkg::LPMKAF_ACT_MC_PTR: begin
					next_rsp.act_ok = !single_key;
					next_rsp.mc_index = act[lpmkaf_pkg::MC_IDX_POS +: 8];
				end
				lpmkaf_pkg::LPMKAF_ACT_INLINE: begin
					next_rsp.act_ok = single_key;
					next_rsp.mac_hi = act[lpmkaf_pkg::MAC_HI_POS +: 16];
					next_rsp.mac_lo = act[lpmkaf_pkg::MAC_LO_POS +: 32];
					next_rsp.leg_id = act[lpmkaf_pkg::LEG_POS +: 5];
					next_rsp.zero_mac_cpu_queue = act[lpmkaf_pkg::CPUQ_POS +: 3];
					next_rsp.reverse_path_check_enable = act[lpmkaf_pkg::RPF_POS];
					next_rsp.leg_match_ena = act[lpmkaf_pkg::LEGM_POS];
					next_rsp.mac_match_ena = act[lpmkaf_pkg::MACM_POS];
					next_rsp.entry_valid = act[lpmkaf_pkg::VALID_POS];
				end
				default: begin
					next_rsp.act_ok = 1'b0;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Response register
	// ----------------------------------------------------------------
	lpmkaf_pkg::lpmkaf_state_t state;

	assign req_ready_o = 1'b1;

	always_ff @(posedge core_clk_i or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			state <= lpmkaf_pkg::LPMKAF_ST_IDLE;
		end else begin
			case (state)
				lpmkaf_pkg::LPMKAF_ST_IDLE: begin
					if (req_valid_i) begin
						state <= lpmkaf_pkg::LPMKAF_ST_DONE;
					end
				end
				lpmkaf_pkg::LPMKAF_ST_DONE: begin
					if (!req_valid_i) begin
						state <= lpmkaf_pkg::LPMKAF_ST_IDLE;
					end
				end
				default: begin
					state <= lpmkaf_pkg::LPMKAF_ST_IDLE;
				end
			endcase
		end
	end

	assign rsp_valid_o = (state == lpmkaf_pkg::LPMKAF_ST_DONE);

	always_ff @(posedge core_clk_i or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			rsp_o <= '0;
			rsp_key_o <= '0;
		end else if (req_valid_i) begin
			rsp_o <= next_rsp;
			rsp_key_o <= packed_key & key_width_mask;
		end
	end

endmodule

// ===== verification/lpm_key_action_format_tb_top.sv
// Self-checking bench for the prefix match store.
`timescale 1ns/1ns
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin miscompares++; \
	$display("unexpected at %0t: got %h expected %h", $time, (g), (e)); end end
module lpm_key_action_format_tb_top;
	logic clk = 1'h0;
	logic rst_b = 1'h0;
	logic wr_en = 1'h0;
	logic [1:0] wr_index = 2'h0;
	logic wr_valid = 1'h0;
	lpmkaf_pkg::lpmkaf_key_t wr_key_type = lpmkaf_pkg::LPMKAF_KEY_SGL4;
	logic [255:0] wr_key = 256'h0;
	logic [255:0] wr_mask = 256'h0;
	logic [61:0] wr_action = 62'h0;
	logic go = 1'h0;
	lpmkaf_pkg::lpmkaf_req_t cmd = '0;
	logic req_valid;
	lpmkaf_pkg::lpmkaf_req_t req;
	logic req_ready;
	logic rsp_valid;
	lpmkaf_pkg::lpmkaf_rsp_t rsp;
	logic [255:0] rsp_key;
	int compares = 0;
	int miscompares = 0;
	always #50 clk = ~clk;
	lpmkaf_lookup_model lpmkaf_lookup_model_inst (.core_clk_i(clk), .go_i(go), .cmd_i(cmd),
		.req_valid_o(req_valid), .req_o(req));
	lpmkaf_store #(.ENTRIES(4)) lpmkaf_store_inst (.core_clk_i(clk), .rst_b_i(rst_b),
		.wr_en_i(wr_en), .wr_index_i(wr_index), .wr_valid_i(wr_valid),
		.wr_key_type_i(wr_key_type), .wr_key_i(wr_key), .wr_mask_i(wr_mask),
		.wr_action_i(wr_action), .req_valid_i(req_valid), .req_i(req), .req_ready_o(req_ready),
		.rsp_valid_o(rsp_valid), .rsp_o(rsp), .rsp_key_o(rsp_key));
	task automatic tally_and_finish();
		$display("compares=%0d miscompares=%0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic wr(input logic [1:0] i, input logic [1:0] t, input logic v,
		input logic [255:0] k, input logic [255:0] m, input logic [61:0] a);
		wr_en <= 1'h1;
		wr_index <= i;
		wr_valid <= v;
		wr_key_type <= lpmkaf_pkg::lpmkaf_key_t'(t);
		wr_key <= k;
		wr_mask <= m;
		wr_action <= a;
		@(posedge clk);
		wr_en <= 1'h0;
		@(posedge clk);
	endtask
	task automatic look(input logic [1:0] t, input logic f, input logic [127:0] s,
		input logic [127:0] d);
		go <= 1'h1;
		cmd <= '{lpmkaf_pkg::lpmkaf_key_t'(t), f, s, d};
		@(posedge clk);
		go <= 1'h0;
		@(posedge clk);
		#1;
		`CHK(rsp_valid, 1'h1)
		@(posedge clk);
	endtask
	task automatic t_sgl4_ptr();
		wr(2'h0, 2'h0, 1'h1, {223'h0, 32'hC0A8_0105, 1'h1}, {223'h0, 33'h1_FFFF_FFFF},
			{44'h0, 3'h5, 4'h9, 1'h1, 8'hA5, 2'h0});
		look(2'h0, 1'h1, 128'h0, 128'hC0A8_0105);
		`CHK(rsp.act_type, 2'h0)
		`CHK({rsp.hit, rsp.act_ok, rsp.nh_index}, {2'h3, 8'hA5})
		`CHK(rsp.remap_ena, 1'h1)
		`CHK(rsp.equal_cost_path_count, 4'h9)
		`CHK(rsp.route_group_identifier, 3'h5)
		look(2'h0, 1'h0, 128'hC0A8_0105, 128'h0);
		`CHK(rsp.hit, 1'h0)
		look(2'h2, 1'h1, 128'h0, 128'hC0A8_0105);
		`CHK(rsp.hit, 1'h0)
		$display("test sgl4_ptr done");
	endtask
	task automatic t_dbl4_mc();
		wr(2'h1, 2'h1, 1'h1, {192'h0, 32'hE000_0001, 32'h0A00_0002}, {192'h0, {64{1'h1}}},
			{52'h0, 8'h3C, 2'h1});
		look(2'h1, 1'h0, 128'h0A00_0002, 128'hE000_0001);
		`CHK({rsp.hit, rsp.act_ok, rsp.act_type}, 4'hD)
		`CHK(rsp.mc_index, 8'h3C)
		look(2'h1, 1'h0, 128'hE000_0001, 128'h0A00_0002);
		`CHK(rsp.hit, 1'h0)
		$display("test dbl4_mc done");
	endtask
	task automatic t_inline_v6();
		wr(2'h2, 2'h2, 1'h1, {127'h0, 128'h2001_0DB8_0001, 1'h0}, {127'h0, {129{1'h1}}},
			{4'hD, 3'h6, 5'h13, 32'h89AB_CDEF, 16'h1234, 2'h2});
		look(2'h2, 1'h0, 128'h2001_0DB8_0001, 128'h0);
		`CHK({rsp.act_ok, rsp.act_type}, 3'h6)
		`CHK({rsp.mac_hi, rsp.mac_lo}, 48'h1234_89AB_CDEF)
		`CHK(rsp[11:0], 12'h9EB)
		$display("test inline_v6 done");
	endtask
	task automatic t_prio();
		logic [255:0] k;
		k = {223'h0, 32'h0A01_0200, 1'h1};
		wr(2'h0, 2'h0, 1'h1, k, {223'h0, 33'h1_FFFF_FE01}, {52'h0, 8'h11, 2'h0});
		wr(2'h1, 2'h0, 1'h1, k, {223'h0, 33'h1_FE00_0001}, {52'h0, 8'h22, 2'h0});
		look(2'h0, 1'h1, 128'h0, 128'h0A01_02FE);
		`CHK(rsp.nh_index, 8'h11)
		wr(2'h0, 2'h0, 1'h0, 256'h0, 256'h0, 62'h0);
		look(2'h0, 1'h1, 128'h0, 128'h0A01_02FE);
		`CHK(rsp.nh_index, 8'h22)
		$display("test prio done");
	endtask
	task automatic t_dbl6_rsvd();
		wr(2'h3, 2'h3, 1'h1, {128'hFF02_0001, 128'h2001_0002}, {256{1'h1}}, {60'h0, 2'h3});
		look(2'h3, 1'h0, 128'h2001_0002, 128'hFF02_0001);
		`CHK({rsp.hit, rsp.act_ok, rsp.act_type}, 4'hB)
		`CHK(rsp_key, {128'hFF02_0001, 128'h2001_0002})
		$display("test dbl6_rsvd done");
	endtask
	// Every test ends within 12 cycles, so this bound only trips on a hang.
	initial begin
		repeat (2000) @(posedge clk);
		miscompares++;
		tally_and_finish();
	end
	initial begin
		repeat (2) @(posedge clk);
		rst_b <= 1'h1;
		repeat (3) @(posedge clk);
		t_sgl4_ptr();
		t_dbl4_mc();
		t_inline_v6();
		t_prio();
		t_dbl6_rsvd();
		tally_and_finish();
	end
endmodule

// ===== verification/lpmkaf_lookup_model.sv
// Lookup issuer standing in for the routing and guard logic.
`timescale 1ns/1ns
module lpmkaf_lookup_model (
	input wire logic core_clk_i,
	input wire logic go_i,
	input wire lpmkaf_pkg::lpmkaf_req_t cmd_i,
	output logic req_valid_o,
	output lpmkaf_pkg::lpmkaf_req_t req_o
);
	initial begin
		req_valid_o = 1'h0;
		req_o = '0;
	end
	// Idle request lines carry the inverse of the last value, so a store that
	// samples them without valid sees garbage rather than a lucky repeat.
	always @(posedge core_clk_i) begin
		req_valid_o <= go_i;
		req_o <= go_i ? cmd_i : ~req_o;
	end
endmodule

// ===== verification/lpmkaf_store_monitor.sv
// Checker of lookup timing, key packing and action use of the prefix match store.
`timescale 1ns/1ns
module lpmkaf_store_monitor (
	input wire logic core_clk_i,
	input wire logic rst_b_i,
	input wire logic req_valid_i,
	input wire lpmkaf_pkg::lpmkaf_req_t req_i,
	input wire logic req_ready_o,
	input wire logic rsp_valid_o,
	input wire lpmkaf_pkg::lpmkaf_rsp_t rsp_o,
	input wire logic [lpmkaf_pkg::ENTRY_W-1:0] rsp_key_o
);
	logic [1:0] kt;
	logic [127:0] xa;
	logic [255:0] ek;
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rst_b_i);
	assign kt = req_i.key_type;
	assign xa = req_i.lookup_direction_flag ? req_i.dst_addr : req_i.src_addr;
	always_comb begin
		case (kt)
			2'h0: ek = {223'h0, xa[31:0], req_i.lookup_direction_flag};
			2'h1: ek = {192'h0, req_i.dst_addr[31:0], req_i.src_addr[31:0]};
			2'h2: ek = {127'h0, xa, req_i.lookup_direction_flag};
			default: ek = {req_i.dst_addr, req_i.src_addr};
		endcase
	end
	property p_rsp_next; req_valid_i |=> rsp_valid_o; endproperty
	a_rsp_next: assert property (p_rsp_next) else $error("no response");
	property p_rsp_idle; !req_valid_i |=> !rsp_valid_o; endproperty
	a_rsp_idle: assert property (p_rsp_idle) else $error("stray response");
	property p_ready; req_valid_i |-> req_ready_o; endproperty
	a_ready: assert property (p_ready) else $error("lookup refused");
	property p_sgl4; req_valid_i && kt == 2'h0 |=> rsp_key_o == $past(ek); endproperty
	a_sgl4: assert property (p_sgl4) else $error("single v4 key");
	property p_dbl4; req_valid_i && kt == 2'h1 |=> rsp_key_o == $past(ek); endproperty
	a_dbl4: assert property (p_dbl4) else $error("double v4 key");
	property p_sgl6; req_valid_i && kt == 2'h2 |=> rsp_key_o == $past(ek); endproperty
	a_sgl6: assert property (p_sgl6) else $error("single v6 key");
	property p_dbl6; req_valid_i && kt == 2'h3 |=> rsp_key_o == $past(ek); endproperty
	a_dbl6: assert property (p_dbl6) else $error("double v6 key");
	property p_rsvd; rsp_valid_o && rsp_o.act_type == 2'h3 |-> !rsp_o.act_ok; endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved action used");
	property p_single; rsp_valid_o && rsp_o.act_ok && rsp_o.act_type != 2'h1
		|-> $past(kt) inside {2'h0, 2'h2}; endproperty
	a_single: assert property (p_single) else $error("unicast action on double key");
	property p_mc; rsp_valid_o && rsp_o.act_ok && rsp_o.act_type == 2'h1
		|-> $past(kt) inside {2'h1, 2'h3} && rsp_o.nh_index == 8'h00; endproperty
	a_mc: assert property (p_mc) else $error("multicast action misuse");
endmodule
bind lpmkaf_store lpmkaf_store_monitor lpmkaf_store_monitor_inst (.core_clk_i, .rst_b_i,
	.req_valid_i, .req_i, .req_ready_o, .rsp_valid_o, .rsp_o, .rsp_key_o);
